// File: design/level2_cache_controller.sv
// Second-level memory and cache controller top level.
`timescale 1ns/10ps
// Notes on behaviour
// - Cache only on port 0, 32K-256K, four-way.
// - Port 0 above 256K, port 1: RAM only.
// - Default: all memory addressable, no cache.
// - 128-byte lines; low 7 bits ignored.
// - Set index bits 7 up to size-dependent top.
// - Code 000 no cache; 101-111 mean 256K.
// - Tag compared against all four ways.
// - Hit needs tag match plus valid bit.
// - Miss stalls requestor until line fetched.
// - Read miss data forwarded during fetch.
// - Write miss merged into fetched line.
// - Allocate whole line on read or write miss.
// - Writeback only on replacement or command.
// - Evicted lines go to external memory controller.
// - Replace least-recently-used way.
// - Two 256-bit memory ports, shared address and data, one at a time.
// - Bank arrangement fixed at design time.
// - Port memory sizes 64K to 819K.
// - Program miss occupies all banks, one access.
// - Data miss, victim: all banks, consecutive.
// - Global reset selects all-RAM.
// - Local reset keeps mode, invalidates, stalls.
////////////////////////////////////////////////////////////////////////////////
module level2_cache_controller (
  // Clock and resets
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LOCAL_RST_N,
  // Cache size and coherence control
  input wire logic MODE_WR,
  input wire logic [2:0] MODE_IN,
  input wire logic WB_CMD,
  output logic [2:0] MODE_OUT,
  output logic CMD_BUSY,
  // First-level cache requests
  input wire logic REQ,
  input wire logic REQ_PROG,
  input wire logic REQ_WR,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [l2_pkg::DATA_W-1:0] REQ_WDATA,
  input wire logic [l2_pkg::BE_W-1:0] REQ_BE,
  output logic STALL,
  output logic RSP_VALID,
  output logic [l2_pkg::DATA_W-1:0] RSP_DATA,
  // Memory port 0
  output logic P0_EN,
  output logic [l2_pkg::BANKS-1:0] P0_BANK_EN,
  output logic P0_WR,
  output logic [l2_pkg::LOC_W-1:0] P0_ADDR,
  output logic [l2_pkg::BE_W-1:0] P0_BE,
  output logic [l2_pkg::DATA_W-1:0] P0_WDATA,
  input wire logic [l2_pkg::DATA_W-1:0] P0_RDATA,
  // Memory port 1
  output logic P1_EN,
  output logic [l2_pkg::BANKS-1:0] P1_BANK_EN,
  output logic P1_WR,
  output logic [l2_pkg::LOC_W-1:0] P1_ADDR,
  output logic [l2_pkg::BE_W-1:0] P1_BE,
  output logic [l2_pkg::DATA_W-1:0] P1_WDATA,
  input wire logic [l2_pkg::DATA_W-1:0] P1_RDATA,
  // External memory controller
  output logic EXT_REQ,
  output logic EXT_WR,
  output logic [31:0] EXT_ADDR,
  output logic [l2_pkg::BE_W-1:0] EXT_BE,
  output logic [l2_pkg::DATA_W-1:0] EXT_WDATA,
  input wire logic EXT_ACK,
  input wire logic [l2_pkg::DATA_W-1:0] EXT_RDATA
);
  l2_pkg::state_type state_q;
  logic [31:0] addr_q;
  logic wr_q;
  logic prog_q;
  logic [l2_pkg::DATA_W-1:0] wdata_q;
  logic [l2_pkg::BE_W-1:0] be_q;
  logic [2:0] cnt_q;
  logic [10:0] sweep_q;
  logic [2:0] mode_q;
  logic [2:0] new_mode_q;
  logic mode_pend_q;
  logic inval_pend_q;
  logic flush_pend_q;
  logic flush_q;
  logic hit_q;
  logic p1_q;
  logic [1:0] vic_way_q;
  logic [1:0] hit_way_q;
  logic [l2_pkg::LINE_W-1:0] vic_line_q;
  logic [1:0] rdp_q;
  logic [1:0] rb0_q;
  logic [1:0] rb1_q;
  logic stall_q;
  logic busy_q;
  logic rsp_valid_q;
  logic [l2_pkg::DATA_W-1:0] rsp_data_q;
  logic p0_en_q;
  logic p1_en_q;
  logic p_wr_q;
  logic [l2_pkg::LOC_W-1:0] p_addr_q;
  logic [l2_pkg::BE_W-1:0] p_be_q;
  logic [l2_pkg::DATA_W-1:0] p_wdata_q;
  logic ext_req_q;
  logic ext_wr_q;
  logic [31:0] ext_addr_q;
  logic [l2_pkg::BE_W-1:0] ext_be_q;
  logic [l2_pkg::DATA_W-1:0] ext_wdata_q;

  l2_int_if u_if ();

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic [2:0] eff_mode;
  logic cache_on;
  logic [8:0] set_mask;
  logic [8:0] req_set;
  logic [31:0] cache_bytes;
  logic [31:0] p0_off;
  logic [31:0] p1_off;
  logic [31:0] p_off;
  logic in_p0;
  logic in_p1;
  logic blocked;
  logic cacheable;
  logic [2:0] nb;
  logic [2:0] lim;
  logic [1:0] beat0;
  logic [1:0] cur_beat;
  logic sweeping;
  logic [1:0] loc_way;
  logic [l2_pkg::LOC_W-1:0] cache_loc;
  logic in_range;
  logic ext_done;
  logic fill_ack;

  localparam int LOC_W = l2_pkg::LOC_W;

  assign eff_mode = (mode_q > l2_pkg::MODE_MAX) ? l2_pkg::MODE_MAX : mode_q;
  assign cache_on = (eff_mode != l2_pkg::MODE_RESET);
  assign set_mask = 9'h1FF >> (3'h4 - eff_mode);
  assign req_set = addr_q[15:7] & set_mask;
  assign cache_bytes = cache_on ? (l2_pkg::CACHE_MIN_BYTES << (eff_mode - 3'h1)) : 32'h0;
  assign p0_off = addr_q - l2_pkg::P0_BASE;
  assign p1_off = addr_q - l2_pkg::P1_BASE;
  assign in_p0 = (p0_off < l2_pkg::P0_BYTES);
  assign in_p1 = (p1_off < l2_pkg::P1_BYTES);
  assign p_off = in_p1 ? p1_off : p0_off;
  // Port 0 bytes taken by the cache are not reachable as RAM.
  assign blocked = in_p0 && (p0_off < cache_bytes);
  assign cacheable = cache_on && !in_p0 && !in_p1;
  assign nb = (!wr_q && !prog_q) ? l2_pkg::DATA_BEATS : l2_pkg::PROG_BEATS;
  assign lim = (state_q == l2_pkg::ST_PORT || state_q == l2_pkg::ST_EXTD) ? nb :
    l2_pkg::LINE_BEATS;
  assign beat0 = {addr_q[6], addr_q[5] & (wr_q | prog_q)};
  assign cur_beat = 2'(beat0 + cnt_q[1:0]);
  assign in_range = (3'(2'(cnt_q[1:0] - beat0)) < nb);
  assign sweeping = (state_q == l2_pkg::ST_INVAL) || (state_q == l2_pkg::ST_FLUSH) || flush_q;
  assign loc_way = (state_q == l2_pkg::ST_PORT) ? hit_way_q : vic_way_q;
  // Cache data of way w sits in the low part of port 0, one block per way.
  assign cache_loc = LOC_W'((32'(loc_way) << (32'(eff_mode) + 32'h7)) |
    (32'(u_if.idx) << 2) | 32'((state_q == l2_pkg::ST_PORT) ? cur_beat : cnt_q[1:0]));

  ////////////////////////////////////////////////////////////////////////////////
  // Tag store and line buffer control.

  assign u_if.idx = sweeping ? sweep_q[8:0] : req_set;
  assign u_if.line = addr_q[31:7];
  assign u_if.way = (state_q == l2_pkg::ST_LOOK) ? u_if.hit_way : vic_way_q;
  assign u_if.sel_way = (state_q == l2_pkg::ST_LOOK) ? u_if.lru_way :
    ((state_q == l2_pkg::ST_FLUSH) ? sweep_q[10:9] : vic_way_q);
  assign u_if.inv_set = (state_q == l2_pkg::ST_INVAL);
  assign u_if.touch = (state_q == l2_pkg::ST_LOOK && cacheable && u_if.hit) ||
    u_if.fill;
  assign u_if.set_dirty = (state_q == l2_pkg::ST_LOOK) && cacheable && u_if.hit && wr_q;
  assign u_if.fill = (state_q == l2_pkg::ST_FWR) && (cnt_q == lim);
  assign u_if.fill_dirty = wr_q;
  assign u_if.clr_dirty = (state_q == l2_pkg::ST_VWR) && flush_q && ext_done;
  assign u_if.lb_we = (state_q == l2_pkg::ST_VRD && rdp_q[1]) || fill_ack;
  assign u_if.lb_beat = (state_q == l2_pkg::ST_VRD) ? rb1_q : cnt_q[1:0];
  assign u_if.lb_wdata = (state_q == l2_pkg::ST_VRD) ? P0_RDATA : EXT_RDATA;
  assign u_if.lb_merge = wr_q && (cnt_q[1:0] == beat0) && (state_q == l2_pkg::ST_FILL);
  assign u_if.lb_mdata = wdata_q;
  assign u_if.lb_be = be_q;
  assign u_if.lb_rbeat = cnt_q[1:0];

  l2_tag_store u_tags (
    .clk(CLK),
    .t(u_if.tags)
  );

  l2_line_buf u_lbuf (
    .clk(CLK),
    .b(u_if.lbuf)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Port and external access issue.

  logic iss_go;
  logic iss_en;
  logic iss_p1;
  logic iss_wr;
  logic ext_go;
  logic port_done;

  assign iss_go = (state_q == l2_pkg::ST_PORT || state_q == l2_pkg::ST_VRD ||
    state_q == l2_pkg::ST_FWR) && (cnt_q < lim);
  assign iss_p1 = (state_q == l2_pkg::ST_PORT) && !hit_q && p1_q;
  assign iss_en = iss_go && !(state_q == l2_pkg::ST_PORT && !hit_q && blocked);
  assign iss_wr = (state_q == l2_pkg::ST_FWR) || (state_q == l2_pkg::ST_PORT && wr_q);
  assign port_done = (cnt_q == lim) && (rdp_q == 2'h0);
  assign ext_go = (state_q == l2_pkg::ST_VWR || state_q == l2_pkg::ST_FILL ||
    state_q == l2_pkg::ST_EXTD) && (cnt_q < lim) && !ext_req_q;
  assign ext_done = (cnt_q == lim) && !ext_req_q;
  assign fill_ack = (state_q == l2_pkg::ST_FILL) && ext_req_q && EXT_ACK;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      p0_en_q <= 1'b0;
      p1_en_q <= 1'b0;
      p_wr_q <= 1'b0;
      p_addr_q <= '0;
      p_be_q <= '0;
      p_wdata_q <= '0;
      rdp_q <= 2'h0;
      rb0_q <= 2'h0;
      rb1_q <= 2'h0;
    end else begin
      p0_en_q <= iss_en && !iss_p1 && LOCAL_RST_N;
      p1_en_q <= iss_en && iss_p1 && LOCAL_RST_N;
      p_wr_q <= iss_wr;
      p_addr_q <= (state_q == l2_pkg::ST_PORT && !hit_q) ? {p_off[19:6], cur_beat[0]} :
        cache_loc;
      p_be_q <= (state_q == l2_pkg::ST_PORT) ? be_q : {l2_pkg::BE_W{1'b1}};
      p_wdata_q <= (state_q == l2_pkg::ST_FWR) ? u_if.lb_rdata : wdata_q;
      rdp_q <= {rdp_q[0], iss_go && !iss_wr && LOCAL_RST_N};
      rb0_q <= (state_q == l2_pkg::ST_PORT) ? cur_beat : cnt_q[1:0];
      rb1_q <= rb0_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequencer.

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= l2_pkg::ST_IDLE;
      mode_q <= l2_pkg::MODE_RESET;
      new_mode_q <= l2_pkg::MODE_RESET;
      mode_pend_q <= 1'b0;
      inval_pend_q <= 1'b1;
      flush_pend_q <= 1'b0;
      flush_q <= 1'b0;
      addr_q <= '0;
      wr_q <= 1'b0;
      prog_q <= 1'b0;
      wdata_q <= '0;
      be_q <= '0;
      cnt_q <= 3'h0;
      sweep_q <= '0;
      hit_q <= 1'b0;
      p1_q <= 1'b0;
      vic_way_q <= 2'h0;
      hit_way_q <= 2'h0;
      vic_line_q <= '0;
      stall_q <= 1'b1;
      ext_req_q <= 1'b0;
      ext_wr_q <= 1'b0;
      ext_addr_q <= '0;
      ext_be_q <= '0;
      ext_wdata_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else if (!LOCAL_RST_N) begin
      state_q <= l2_pkg::ST_INVAL;
      sweep_q <= '0;
      stall_q <= 1'b1;
      flush_q <= 1'b0;
      ext_req_q <= 1'b0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= (state_q == l2_pkg::ST_PORT) && rdp_q[1];
      rsp_data_q <= blocked ? '0 : (p1_q ? P1_RDATA : P0_RDATA);
      if (ext_go) begin
        ext_req_q <= 1'b1;
        ext_wr_q <= (state_q == l2_pkg::ST_VWR) || (state_q == l2_pkg::ST_EXTD && wr_q);
        ext_addr_q <= (state_q == l2_pkg::ST_VWR) ? {vic_line_q, cnt_q[1:0], 5'h0} :
          {addr_q[31:7], (state_q == l2_pkg::ST_EXTD) ? cur_beat : cnt_q[1:0], 5'h0};
        ext_be_q <= (state_q == l2_pkg::ST_EXTD) ? be_q : {l2_pkg::BE_W{1'b1}};
        ext_wdata_q <= (state_q == l2_pkg::ST_VWR) ? u_if.lb_rdata : wdata_q;
      end else if (ext_req_q && EXT_ACK) begin
        ext_req_q <= 1'b0;
        cnt_q <= 3'(cnt_q + 3'h1);
        if ((fill_ack && !wr_q && in_range) || (state_q == l2_pkg::ST_EXTD && !wr_q)) begin
          rsp_valid_q <= 1'b1;
          rsp_data_q <= EXT_RDATA;
        end
      end
      if (iss_go) begin
        cnt_q <= 3'(cnt_q + 3'h1);
      end
      case (state_q)
        l2_pkg::ST_IDLE: begin
          cnt_q <= 3'h0;
          sweep_q <= '0;
          if (inval_pend_q) begin
            inval_pend_q <= 1'b0;
            state_q <= l2_pkg::ST_INVAL;
            stall_q <= 1'b1;
          end else if (mode_pend_q || flush_pend_q) begin
            flush_pend_q <= 1'b0;
            state_q <= cache_on ? l2_pkg::ST_FLUSH : l2_pkg::ST_INVAL;
            stall_q <= 1'b1;
          end else if (REQ) begin
            addr_q <= REQ_ADDR;
            wr_q <= REQ_WR;
            prog_q <= REQ_PROG;
            wdata_q <= REQ_WDATA;
            be_q <= REQ_BE;
            state_q <= l2_pkg::ST_LOOK;
            stall_q <= 1'b1;
          end
        end
        l2_pkg::ST_LOOK: begin
          hit_q <= cacheable && u_if.hit;
          hit_way_q <= u_if.hit_way;
          p1_q <= in_p1;
          vic_way_q <= u_if.lru_way;
          vic_line_q <= u_if.sel_line;
          if (!cacheable) begin
            state_q <= (in_p0 || in_p1) ? l2_pkg::ST_PORT : l2_pkg::ST_EXTD;
          end else if (u_if.hit) begin
            state_q <= l2_pkg::ST_PORT;
          end else if (u_if.sel_valid && u_if.sel_dirty) begin
            state_q <= l2_pkg::ST_VRD;
          end else begin
            state_q <= l2_pkg::ST_FILL;
          end
        end
        l2_pkg::ST_PORT, l2_pkg::ST_EXTD: begin
          if ((state_q == l2_pkg::ST_PORT) ? port_done : ext_done) begin
            state_q <= l2_pkg::ST_IDLE;
            stall_q <= 1'b0;
          end
        end
        l2_pkg::ST_VRD: begin
          if (port_done) begin
            cnt_q <= 3'h0;
            state_q <= l2_pkg::ST_VWR;
          end
        end
        l2_pkg::ST_VWR: begin
          if (ext_done) begin
            cnt_q <= 3'h0;
            flush_q <= 1'b0;
            state_q <= flush_q ? l2_pkg::ST_FLUSH : l2_pkg::ST_FILL;
          end
        end
        l2_pkg::ST_FILL: begin
          if (ext_done) begin
            cnt_q <= 3'h0;
            state_q <= l2_pkg::ST_FWR;
          end
        end
        l2_pkg::ST_FWR: begin
          if (cnt_q == lim) begin
            state_q <= l2_pkg::ST_IDLE;
            stall_q <= 1'b0;
          end
        end
        l2_pkg::ST_INVAL: begin
          sweep_q <= 11'(sweep_q + 11'h1);
          if (sweep_q[8:0] == l2_pkg::SET_LAST) begin
            if (mode_pend_q) begin
              mode_q <= new_mode_q;
              mode_pend_q <= 1'b0;
            end
            state_q <= l2_pkg::ST_IDLE;
            stall_q <= 1'b0;
          end
        end
        l2_pkg::ST_FLUSH: begin
          if (u_if.sel_valid && u_if.sel_dirty) begin
            vic_way_q <= sweep_q[10:9];
            vic_line_q <= u_if.sel_line;
            flush_q <= 1'b1;
            cnt_q <= 3'h0;
            state_q <= l2_pkg::ST_VRD;
          end else if (sweep_q == l2_pkg::SWEEP_LAST) begin
            sweep_q <= '0;
            state_q <= mode_pend_q ? l2_pkg::ST_INVAL : l2_pkg::ST_IDLE;
            stall_q <= mode_pend_q;
          end else begin
            sweep_q <= 11'(sweep_q + 11'h1);
          end
        end
        default: begin
          state_q <= l2_pkg::ST_IDLE;
          stall_q <= 1'b0;
        end
      endcase
      if (MODE_WR) begin
        mode_pend_q <= 1'b1;
        new_mode_q <= MODE_IN;
      end
      if (WB_CMD) begin
        flush_pend_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_q <= 1'b1;
    end else begin
      busy_q <= mode_pend_q || flush_pend_q || inval_pend_q || flush_q ||
        state_q == l2_pkg::ST_FLUSH || state_q == l2_pkg::ST_INVAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign MODE_OUT = mode_q;
  assign CMD_BUSY = busy_q;
  assign STALL = stall_q;
  assign RSP_VALID = rsp_valid_q;
  assign RSP_DATA = rsp_data_q;
  assign P0_EN = p0_en_q;
  assign P0_BANK_EN = {l2_pkg::BANKS{p0_en_q}};
  assign P0_WR = p_wr_q;
  assign P0_ADDR = p_addr_q;
  assign P0_BE = p_be_q;
  assign P0_WDATA = p_wdata_q;
  assign P1_EN = p1_en_q;
  assign P1_BANK_EN = {l2_pkg::BANKS{p1_en_q}};
  assign P1_WR = p_wr_q;
  assign P1_ADDR = p_addr_q;
  assign P1_BE = p_be_q;
  assign P1_WDATA = p_wdata_q;
  assign EXT_REQ = ext_req_q;
  assign EXT_WR = ext_wr_q;
  assign EXT_ADDR = ext_addr_q;
  assign EXT_BE = ext_be_q;
  assign EXT_WDATA = ext_wdata_q;
endmodule

// File: design/l2_pkg.sv
// Constants and types shared by the second-level cache controller files.
package l2_pkg;
  localparam int WAYS = 4;
  localparam int SETS = 512;
  localparam int SET_W = 9;
  localparam int LINE_W = 25;
  localparam int DATA_W = 256;
  localparam int BE_W = 32;
  localparam int LOC_W = 15;
  localparam int BANKS = 2;
  localparam int OFFSET_BITS = 7;
  localparam logic [2:0] LINE_BEATS = 3'h4;
  localparam logic [2:0] PROG_BEATS = 3'h1;
  localparam logic [2:0] DATA_BEATS = 3'h2;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_MAX = 3'h4;
  localparam logic [31:0] CACHE_MIN_BYTES = 32'h0000_8000;
  localparam logic [31:0] P0_BASE = 32'h0080_0000;
  localparam logic [31:0] P0_BYTES = 32'h0008_0000;
  localparam logic [31:0] P1_BASE = 32'h0090_0000;
  localparam logic [31:0] P1_BYTES = 32'h0004_0000;
  localparam logic [7:0] AGE_INIT = 8'hE4;
  localparam logic [10:0] SWEEP_LAST = 11'h7FF;
  localparam logic [8:0] SET_LAST = 9'h1FF;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_LOOK = 4'h1,
    ST_PORT = 4'h3,
    ST_VRD = 4'h2,
    ST_VWR = 4'h6,
    ST_FILL = 4'h7,
    ST_FWR = 4'h5,
    ST_EXTD = 4'h4,
    ST_INVAL = 4'hC,
    ST_FLUSH = 4'hD
  } state_type;
endpackage

// File: design/l2_int_if.sv
// Signals between the controller, its tag store and its line buffer.
`timescale 1ns/10ps
interface l2_int_if;
  logic [l2_pkg::SET_W-1:0] idx;
  logic [l2_pkg::LINE_W-1:0] line;
  logic [1:0] way;
  logic [1:0] sel_way;
  logic touch;
  logic fill;
  logic fill_dirty;
  logic set_dirty;
  logic clr_dirty;
  logic inv_set;
  logic hit;
  logic [1:0] hit_way;
  logic [1:0] lru_way;
  logic sel_valid;
  logic sel_dirty;
  logic [l2_pkg::LINE_W-1:0] sel_line;
  logic lb_we;
  logic lb_merge;
  logic [1:0] lb_beat;
  logic [1:0] lb_rbeat;
  logic [l2_pkg::DATA_W-1:0] lb_wdata;
  logic [l2_pkg::DATA_W-1:0] lb_mdata;
  logic [l2_pkg::DATA_W-1:0] lb_rdata;
  logic [l2_pkg::BE_W-1:0] lb_be;
  modport ctl (output idx, line, way, sel_way, touch, fill, fill_dirty, set_dirty, clr_dirty,
    inv_set, lb_we, lb_merge, lb_beat, lb_rbeat, lb_wdata, lb_mdata, lb_be,
    input hit, hit_way, lru_way, sel_valid, sel_dirty, sel_line, lb_rdata);
  modport tags (input idx, line, way, sel_way, touch, fill, fill_dirty, set_dirty, clr_dirty,
    inv_set, output hit, hit_way, lru_way, sel_valid, sel_dirty, sel_line);
  modport lbuf (input lb_we, lb_merge, lb_beat, lb_rbeat, lb_wdata, lb_mdata, lb_be,
    output lb_rdata);
endinterface

// File: design/l2_tag_store.sv
// Four-way tag, valid, dirty and age store with lookup.
`timescale 1ns/10ps
module l2_tag_store (
  // Clock
  input wire logic clk,
  // Controller side
  l2_int_if.tags t
);
  logic [l2_pkg::LINE_W-1:0] tag_q [l2_pkg::SETS][l2_pkg::WAYS];
  logic [l2_pkg::WAYS-1:0] valid_q [l2_pkg::SETS];
  logic [l2_pkg::WAYS-1:0] dirty_q [l2_pkg::SETS];
  logic [7:0] age_q [l2_pkg::SETS];
  logic [3:0] hitv;
  logic [3:0] lruv;
  logic [7:0] age_cur;
  logic [7:0] age_d;
  logic [1:0] age_sel;

  assign age_cur = age_q[t.idx];
  assign age_sel = age_cur[2*t.way +: 2];

  // Each way compares its stored line tag and checks the valid bit.
  for (genvar w = 0; w < l2_pkg::WAYS; w++) begin : g_way
    logic [1:0] age_w;
    assign age_w = age_cur[2*w +: 2];
    assign hitv[w] = valid_q[t.idx][w] && (tag_q[t.idx][w] == t.line);
    assign lruv[w] = (age_w == 2'h3);
    assign age_d[2*w +: 2] = (2'(w) == t.way) ? 2'h0 :
      ((age_w < age_sel) ? 2'(age_w + 2'h1) : age_w);
  end

  assign t.hit = |hitv;
  assign t.hit_way = {hitv[3] | hitv[2], hitv[3] | hitv[1]};
  assign t.lru_way = {lruv[3] | lruv[2], lruv[3] | lruv[1]};
  assign t.sel_valid = valid_q[t.idx][t.sel_way];
  assign t.sel_dirty = dirty_q[t.idx][t.sel_way];
  assign t.sel_line = tag_q[t.idx][t.sel_way];

  always_ff @(posedge clk) begin
    if (t.inv_set) begin
      valid_q[t.idx] <= '0;
      dirty_q[t.idx] <= '0;
      age_q[t.idx] <= l2_pkg::AGE_INIT;
    end else begin
      if (t.fill) begin
        tag_q[t.idx][t.way] <= t.line;
        valid_q[t.idx][t.way] <= 1'b1;
        dirty_q[t.idx][t.way] <= t.fill_dirty;
      end
      if (t.set_dirty) begin
        dirty_q[t.idx][t.way] <= 1'b1;
      end
      if (t.clr_dirty) begin
        dirty_q[t.idx][t.way] <= 1'b0;
      end
      if (t.touch) begin
        age_q[t.idx] <= age_d;
      end
    end
  end
endmodule

// File: design/l2_line_buf.sv
// Buffer for one 128-byte line with write merge.
`timescale 1ns/10ps
module l2_line_buf (
  // Clock
  input wire logic clk,
  // Controller side
  l2_int_if.lbuf b
);
  logic [l2_pkg::DATA_W-1:0] mem_q [4];
  logic [l2_pkg::DATA_W-1:0] merged;

  // Enabled write bytes replace the fetched bytes.
  for (genvar i = 0; i < l2_pkg::BE_W; i++) begin : g_byte
    assign merged[8*i +: 8] = (b.lb_merge && b.lb_be[i]) ? b.lb_mdata[8*i +: 8] :
      b.lb_wdata[8*i +: 8];
  end

  assign b.lb_rdata = mem_q[b.lb_rbeat];

  always_ff @(posedge clk) begin
    if (b.lb_we) begin
      mem_q[b.lb_beat] <= merged;
    end
  end
endmodule

// File: dv/l2_far_model.sv
// Models of one memory port and of the external memory controller.
`timescale 1ns/10ps
module l2_port_model (
  // Clock
  input wire logic clk,
  // Port side
  input wire logic en,
  input wire logic wr,
  input wire logic [l2_pkg::LOC_W-1:0] addr,
  input wire logic [l2_pkg::BE_W-1:0] be,
  input wire logic [l2_pkg::DATA_W-1:0] wdata,
  output logic [l2_pkg::DATA_W-1:0] rdata
);
  logic [l2_pkg::DATA_W-1:0] mem [int];
  initial rdata = '0;
  // Outside a read answer the data lines keep changing.
  always @(posedge clk) begin
    rdata <= ~rdata;
    if (en && !mem.exists(addr)) begin
      mem[addr] = '0;
    end
    if (en && wr) begin
      for (int i = 0; i < l2_pkg::BE_W; i++) begin
        if (be[i]) mem[addr][i*8 +: 8] = wdata[i*8 +: 8];
      end
    end else if (en) begin
      rdata <= mem[addr];
    end
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
module l2_ext_model (
  // Clock
  input wire logic clk,
  // Request side
  input wire logic req,
  input wire logic [31:0] addr,
  output logic ack,
  output logic [l2_pkg::DATA_W-1:0] rdata
);
  logic [1:0] wait_q = '0;
  initial ack = '0;
  initial rdata = '0;
  // Answers each beat slowly, with data made from its address.
  always @(posedge clk) begin
    ack <= '0;
    rdata <= ~rdata;
    wait_q <= (req && !ack) ? wait_q + 2'h1 : 2'h0;
    if (req && !ack && wait_q == 2'h2) begin
      ack <= '1;
      rdata <= {8{addr}};
    end
  end
endmodule

// File: dv/l2_cache_props.sv
// Port-level checks on the second-level cache controller.
`timescale 1ns/10ps
module l2_cache_props (
  // Clock and resets
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LOCAL_RST_N,
  // Watched ports
  input wire logic REQ,
  input wire logic REQ_PROG,
  input wire logic REQ_WR,
  input wire logic [31:0] REQ_ADDR,
  input wire logic STALL,
  input wire logic RSP_VALID,
  input wire logic [2:0] MODE_OUT,
  input wire logic P0_EN,
  input wire logic [l2_pkg::BANKS-1:0] P0_BANK_EN,
  input wire logic P1_EN,
  input wire logic EXT_REQ,
  input wire logic EXT_ACK
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire p1_rd = REQ && !STALL && !REQ_WR && REQ_ADDR[31:18] == 14'h0024;
  chk_take_stall: assert property (REQ && !STALL |=> STALL)
    else $error("stall not raised");
  chk_data_beats: assert property (p1_rd && !REQ_PROG |-> ##3 P1_EN [*2] ##1 !P1_EN)
    else $error("data read beats");
  chk_prog_beat: assert property (p1_rd && REQ_PROG |-> ##3 P1_EN ##1 !P1_EN)
    else $error("program read beat");
  chk_read_answer: assert property (p1_rd && !REQ_PROG |-> ##[4:5] RSP_VALID [*2])
    else $error("read answer");
  chk_all_banks: assert property (P0_EN |-> &P0_BANK_EN)
    else $error("bank enables");
  chk_local_stall: assert property (!LOCAL_RST_N |=> STALL)
    else $error("local reset stall");
  chk_local_mode: assert property (!LOCAL_RST_N |=> $stable(MODE_OUT))
    else $error("local reset mode");
  chk_ext_hold: assert property (EXT_REQ && !EXT_ACK && LOCAL_RST_N |=> EXT_REQ)
    else $error("external request dropped");
  cov_port_read: cover property (p1_rd);
  cov_ext_beat: cover property (EXT_ACK);
  cov_local: cover property ($fell(LOCAL_RST_N));
endmodule
bind level2_cache_controller l2_cache_props l2_cache_props_inst (.*);

// File: dv/level2_cache_controller_tb.sv
// Self-checking bench for the second-level cache controller.
`timescale 1ns/10ps
module level2_cache_controller_tb;
  logic CLK = '0, RST_N = '0, LOCAL_RST_N = '1, MODE_WR = '0, WB_CMD = '0;
  logic REQ = '0, REQ_PROG = '0, REQ_WR = '0, EXT_ACK, CMD_BUSY, STALL, RSP_VALID;
  logic P0_EN, P0_WR, P1_EN, P1_WR, EXT_REQ, EXT_WR;
  logic [2:0] MODE_IN = '0, MODE_OUT;
  logic [31:0] REQ_ADDR = '0, REQ_BE = '1, P0_BE, P1_BE, EXT_BE, EXT_ADDR;
  logic [255:0] REQ_WDATA = '0, RSP_DATA, P0_WDATA, P0_RDATA, P1_WDATA, P1_RDATA;
  logic [255:0] EXT_WDATA, EXT_RDATA, wb_d = '0;
  logic [1:0] P0_BANK_EN, P1_BANK_EN;
  logic [14:0] P0_ADDR, P1_ADDR;
  logic [255:0] beats [$];
  int mismatches = 0, comparisons = 0, cyc = 0, ext_n = 0, ext_wr = 0;
  level2_cache_controller level2_cache_controller_inst (.*);
  l2_port_model l2_port_model_inst (.clk(CLK), .en(P0_EN), .wr(P0_WR), .addr(P0_ADDR),
    .be(P0_BE), .wdata(P0_WDATA), .rdata(P0_RDATA));
  l2_port_model l2_port_model_1_inst (.clk(CLK), .en(P1_EN), .wr(P1_WR), .addr(P1_ADDR),
    .be(P1_BE), .wdata(P1_WDATA), .rdata(P1_RDATA));
  l2_ext_model l2_ext_model_inst (.clk(CLK), .req(EXT_REQ), .addr(EXT_ADDR), .ack(EXT_ACK),
    .rdata(EXT_RDATA));
  initial forever #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (EXT_REQ && EXT_ACK) ext_n++;
    if (EXT_REQ && EXT_ACK && EXT_WR) ext_wr++;
    if (EXT_REQ && EXT_ACK && EXT_WR && EXT_ADDR == 32'h1000_0000) wb_d = EXT_WDATA;
    if (cyc == 30000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input string s, input logic [255:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // One request, held for one cycle; read beats are collected until the stall ends.
  task automatic xfer(input logic p, w, input logic [31:0] a, input logic [255:0] d);
    int n;
    n = 0;
    beats = {};
    while (STALL !== 1'h0) @(negedge CLK);
    {REQ, REQ_PROG, REQ_WR, REQ_ADDR, REQ_WDATA} = {1'h1, p, w, a, d};
    do begin
      @(negedge CLK);
      if (n == 0) REQ = '0;
      if (RSP_VALID === 1'h1) beats.push_back(RSP_DATA);
      n++;
    end while (STALL !== 1'h0);
  endtask
  task automatic pulse_wait(input logic m);
    {MODE_WR, WB_CMD} = {m, !m};
    @(negedge CLK);
    {MODE_WR, WB_CMD} = 2'h0;
    repeat (2) @(negedge CLK);
    while (CMD_BUSY !== 1'h0 || STALL !== 1'h0) @(negedge CLK);
  endtask
  task automatic t_ram();
    xfer('0, '1, 32'h0090_0040, {8{32'hA5A5_0001}});
    xfer('0, '1, 32'h0090_0060, {8{32'h5A5A_0002}});
    xfer('0, '0, 32'h0090_0040, '0);
    chk("beats", 2, beats.size());
    chk("p1 b0", {8{32'hA5A5_0001}}, beats[0]);
    chk("p1 b1", {8{32'h5A5A_0002}}, beats[1]);
    xfer('1, '0, 32'h0090_0060, '0);
    chk("prog", {8{32'h5A5A_0002}}, beats[0]);
    xfer('0, '0, 32'h1000_0100, '0);
    chk("ext rd", {8{32'h1000_0120}}, beats[1]);
  endtask
  task automatic t_mode();
    MODE_IN = 3'h1;
    pulse_wait('1);
    chk("mode", 3'h1, MODE_OUT);
    xfer('0, '1, 32'h0083_0000, {8{32'hC3C3_0003}});
    xfer('1, '0, 32'h0083_0000, '0);
    chk("p0 ram", {8{32'hC3C3_0003}}, beats[0]);
    MODE_IN = 3'h7;
    pulse_wait('1);
    xfer('1, '0, 32'h0083_0000, '0);
    chk("p0 cache", '0, beats[0]);
  endtask
  task automatic t_cache();
    MODE_IN = 3'h1;
    pulse_wait('1);
    xfer('0, '0, 32'h1000_0000, '0);
    chk("miss b1", {8{32'h1000_0020}}, beats[1]);
    chk("ext", 6, ext_n);
    xfer('0, '0, 32'h1000_0000, '0);
    chk("hit b0", {8{32'h1000_0000}}, beats[0]);
    xfer('0, '1, 32'h1000_0080, {8{32'h7E7E_0004}});
    xfer('0, '0, 32'h1000_0080, '0);
    chk("merge", {8{32'h7E7E_0004}}, beats[0]);
    chk("ext", 10, ext_n);
    xfer('0, '1, 32'h1000_0000, {8{32'h7E7E_0005}});
    pulse_wait('0);
    chk("wb", 8, ext_wr);
    chk("wb data", {8{32'h7E7E_0005}}, wb_d);
  endtask
  task automatic t_local();
    LOCAL_RST_N = '0;
    repeat (3) @(negedge CLK);
    LOCAL_RST_N = '1;
    chk("mode kept", 3'h1, MODE_OUT);
    xfer('0, '0, 32'h1000_0000, '0);
    chk("ext", 22, ext_n);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge CLK);
    RST_N = '1;
    chk("reset mode", 3'h0, MODE_OUT);
    chk("reset busy", 2'h3, {CMD_BUSY, STALL});
    t_ram();
    t_mode();
    t_cache();
    t_local();
    end_of_test();
  end
endmodule
